// *** core/gocd_regs.svh ***
// Register indices, field positions, reset values and timing constants
// of the gauge option decoder.
// Assumes inclusion by bare name from every file that needs them.
`ifndef GOCD_REGS_SVH
`define GOCD_REGS_SVH
// Word indices; the byte address on the bus is four times the index.
`define GOCD_IDX_SPEC 8'h06
`define GOCD_IDX_DATE 8'h08
`define GOCD_IDX_SERIAL 8'h0A
`define GOCD_IDX_MNAME_LEN 8'h0E
`define GOCD_IDX_DNAME_LEN 8'h1A
`define GOCD_IDX_PACK 8'h28
`define GOCD_IDX_GAUGE 8'h29
`define GOCD_IDX_MISC 8'h2A
`define GOCD_IDX_CTRL 8'h30
`define GOCD_IDX_STATUS 8'h31
// Reset values; the misc word carries its fixed-one position.
`define GOCD_RST_ZERO 16'h0000
`define GOCD_RST_MISC 16'h0200
`define GOCD_RST_CTRL 16'h001E
// Pack option bits.
`define GOCD_PK_LED_SRC 7
`define GOCD_PK_SEG_HI 6
`define GOCD_PK_SEG_LO 5
`define GOCD_PK_HOST_CRC 4
`define GOCD_PK_CHG_CRC 3
`define GOCD_PK_SUPPRESS 2
`define GOCD_PK_CELL_HI 1
`define GOCD_PK_CELL_LO 0
// Gauge option bits.
`define GOCD_GA_SYNC 6
`define GOCD_GA_INDEP 5
`define GOCD_GA_COMP 4
`define GOCD_GA_EDV_PACK 3
`define GOCD_GA_OV_CELL 2
`define GOCD_GA_CONT_FIX 1
`define GOCD_GA_ONE_FIX 0
// Misc option bits.
`define GOCD_MI_SENSOR 15
`define GOCD_MI_AFE_CHECK 13
`define GOCD_MI_SLEEP_INH 12
`define GOCD_MI_OT_DSG 11
`define GOCD_MI_CHG_DISP 10
`define GOCD_MI_CELL_DLY 8
`define GOCD_MI_ALARM_OFF 7
`define GOCD_MI_PRE_HI 6
`define GOCD_MI_PRE_LO 5
`define GOCD_MI_FIXED 4
`define GOCD_MI_RETAIN 3
// Own control word: fault reset seconds and failure configuration.
`define GOCD_CT_FRT_HI 7
`define GOCD_CT_FRT_LO 0
`define GOCD_CT_PF_AFE 11
// Status bits.
`define GOCD_ST_AFE_FAIL 0
// Times in their own units and the core clock rate.
`define GOCD_CLK_HZ 50000000
`define GOCD_SLEEP_IDLE_S 2
`define GOCD_CELL_DELAY_S 1
`define GOCD_SECOND_S 1
`endif

// *** core/gocd_pkg.sv ***
// Types shared by the gauge option decoder.
// Assumes the constants header is included alongside.
package gocd_pkg;
	typedef logic [15:0] gocd_word_t;
	typedef enum logic [1:0] {
		GOCD_PRE_ZERO_VOLT = 2'b00,
		GOCD_PRE_CHARGE = 2'b01,
		GOCD_PRE_ALT = 2'b10,
		GOCD_PRE_UNDEF = 2'b11
	} gocd_prechg_e;
endpackage

// *** core/gocd_top.sv ***
// Option byte decoder of the gas gauge with its APB register slave.
// Assumes one 50 MHz clock; gauge engine inputs share it, bus pins do not.
`timescale 1ns/1ps
`include "gocd_regs.svh"

// Overview of operation
// RULE_01 - LED source: 0 absolute, 1 relative charge
// RULE_02 - Segment field: 00/11 five, 01 three, 10 four
// RULE_03 - Host alert crc byte follows its bit
// RULE_04 - Charger broadcast crc byte follows its bit
// RULE_05 - Suppress bit blocks all broadcasts regardless of mode
// RULE_06 - Cell field: 11 four, 10 three, 01 two
// RULE_07 - Sync bit loads capacity on valid termination
// RULE_08 - Learning tuned for independent or smart charger
// RULE_09 - Compensation bit selects computed or fixed thresholds
// RULE_10 - End voltage basis: pack or lowest cell
// RULE_11 - Safety limit: pack voltage or scaled highest cell
// RULE_12 - Midrange fix continuous, or once after reset
// RULE_13 - Sensor bit: internal sensor or external thermistor
// RULE_14 - Front end check; failure needs config bit three
// RULE_15 - Sleep after bus low two seconds unless inhibited
// RULE_16 - Overheat: charge switch off, discharge per bit
// RULE_17 - LEDs while charging only with display bit
// RULE_18 - Cell flags delayed one second when enabled
// RULE_19 - Capacity alarm: blink or dark per bit
// RULE_20 - Precharge switch chosen by two-bit field
// RULE_21 - Fixed battery: extra fault clears, keep other switch
// RULE_22 - Retention bit keeps charge switch after termination
// RULE_23 - Fixed positions are ignored by decoding
module gocd_top
	import gocd_pkg::*;
#(
	parameter int SLEEP_CYCLES = `GOCD_SLEEP_IDLE_S * `GOCD_CLK_HZ,
	parameter int DELAY_CYCLES = `GOCD_CELL_DELAY_S * `GOCD_CLK_HZ,
	parameter int SECOND_CYCLES = `GOCD_SECOND_S * `GOCD_CLK_HZ
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic smb_clk_pin,
	input wire logic smb_data_pin,
	input wire logic mode_broadcast_enable,
	input wire logic charge_term_valid,
	input wire logic charge_restart,
	input wire logic overtemp,
	input wire logic rca_alarm,
	input wire logic discharging,
	input wire logic cell_high_raw,
	input wire logic cell_low_raw,
	input wire logic afe_comm_error,
	input wire logic chg_fault_evt,
	input wire logic dsg_fault_evt,
	input wire logic pack_removed,
	input wire logic current_charging,
	input wire logic current_discharging,
	input wire logic avg_below_clear,
	output logic led_source_select,
	output logic [2:0] led_segments,
	output logic host_alert_crc_enable,
	output logic charger_broadcast_crc_enable,
	output logic host_broadcast_enable,
	output logic charger_broadcast_enable,
	output logic [2:0] series_cells,
	output logic rm_load_pulse,
	output logic independent_charger_learning,
	output logic end_threshold_compensation,
	output logic end_voltage_basis,
	output logic safety_voltage_basis,
	output logic continuous_midrange_fix,
	output logic midrange_oneshot_pulse,
	output logic on_chip_sensor_select,
	output logic front_end_link_check,
	output logic afe_fail_flag,
	output logic sleep_request,
	output logic led_enable,
	output logic led_blink,
	output logic cell_high_flag,
	output logic cell_low_flag,
	output logic zero_volt_charge_switch,
	output logic chg_precharge_switch,
	output logic alt_precharge_switch,
	output logic chg_fet_on,
	output logic dsg_fet_on,
	output logic chg_fault,
	output logic dsg_fault
);

	////////////////////////////////////////////////////////////////////////
	// Register slots and decoding.
	localparam logic [3:0] SLOT_NONE = 4'hF;
	localparam logic [3:0] SLOT_STATUS = 4'h9;
	localparam int NSLOT = 9;
	localparam gocd_word_t WMASK [NSLOT] = '{16'hFFFF, 16'hFFFF, 16'hFFFF,
		16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'hFFFF, 16'hFFFF};
	localparam gocd_word_t RSTV [NSLOT] = '{`GOCD_RST_ZERO, `GOCD_RST_ZERO,
		`GOCD_RST_ZERO, `GOCD_RST_ZERO, `GOCD_RST_ZERO, `GOCD_RST_ZERO,
		`GOCD_RST_ZERO, `GOCD_RST_MISC, `GOCD_RST_CTRL};

	// Maps a byte address onto a slot; misaligned words are unmapped.
	function automatic logic [3:0] slot_of(input logic [9:0] addr);
		logic [3:0] s;
		s = SLOT_NONE;
		if (addr[1:0] == 2'b00) begin
			unique case (addr[9:2])
				`GOCD_IDX_SPEC: s = 4'h0;
				`GOCD_IDX_DATE: s = 4'h1;
				`GOCD_IDX_SERIAL: s = 4'h2;
				`GOCD_IDX_MNAME_LEN: s = 4'h3;
				`GOCD_IDX_DNAME_LEN: s = 4'h4;
				`GOCD_IDX_PACK: s = 4'h5;
				`GOCD_IDX_GAUGE: s = 4'h6;
				`GOCD_IDX_MISC: s = 4'h7;
				`GOCD_IDX_CTRL: s = 4'h8;
				`GOCD_IDX_STATUS: s = SLOT_STATUS;
				default: s = SLOT_NONE;
			endcase
		end
		return s;
	endfunction

	logic [3:0] slot;
	logic wr_en;
	gocd_word_t cfg_ff [NSLOT];
	gocd_word_t nxt_cfg [NSLOT];
	gocd_word_t lane_mask;
	gocd_word_t status_word;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;

	// The read word is captured in the setup cycle, so every access
	// takes exactly one access cycle and prdata comes from a flop.
	assign slot = slot_of(paddr);
	assign pready = psel & penable;
	assign pslverr = psel & penable & (slot == SLOT_NONE);
	assign wr_en = psel & penable & pwrite & (slot != SLOT_NONE);
	assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	assign prdata = prdata_ff;

	// Byte-lane writes into the option words; high lanes read as zero.
	always_comb begin
		for (int i = 0; i < NSLOT; i++) begin
			nxt_cfg[i] = cfg_ff[i];
			if (wr_en && slot == 4'(i)) begin
				nxt_cfg[i] = ((cfg_ff[i] & ~lane_mask) |
					(pwdata[15:0] & lane_mask)) & WMASK[i];
			end
		end
		nxt_prdata = prdata_ff;
		if (psel && !penable) begin
			nxt_prdata = 32'h0000_0000;
			if (slot == SLOT_STATUS) begin
				nxt_prdata[15:0] = status_word;
			end else if (slot != SLOT_NONE) begin
				nxt_prdata[15:0] = cfg_ff[slot];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= RSTV;
			prdata_ff <= 32'h0000_0000;
		end else begin
			cfg_ff <= nxt_cfg;
			prdata_ff <= nxt_prdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Plain decoding; fixed positions are never looked at.
	gocd_word_t pack_w;
	gocd_word_t gauge_w;
	gocd_word_t misc_w;
	gocd_word_t ctrl_w;
	gocd_prechg_e pre_sel;
	assign pack_w = cfg_ff[5];
	assign gauge_w = cfg_ff[6];
	assign misc_w = cfg_ff[7];
	assign ctrl_w = cfg_ff[8];
	assign pre_sel = gocd_prechg_e'(misc_w[`GOCD_MI_PRE_HI:`GOCD_MI_PRE_LO]);

	always_comb begin
		led_source_select = pack_w[`GOCD_PK_LED_SRC]; // RULE_01 RULE_23
		unique case (pack_w[`GOCD_PK_SEG_HI:`GOCD_PK_SEG_LO]) // RULE_02
			2'b01: led_segments = 3'h3;
			2'b10: led_segments = 3'h4;
			default: led_segments = 3'h5;
		endcase
		host_alert_crc_enable = pack_w[`GOCD_PK_HOST_CRC]; // RULE_03
		charger_broadcast_crc_enable = pack_w[`GOCD_PK_CHG_CRC]; // RULE_04
		// Mode bits alone cannot reopen broadcasts while suppressed.
		host_broadcast_enable = mode_broadcast_enable &
			!pack_w[`GOCD_PK_SUPPRESS]; // RULE_05
		charger_broadcast_enable = host_broadcast_enable; // RULE_05
		unique case (pack_w[`GOCD_PK_CELL_HI:`GOCD_PK_CELL_LO]) // RULE_06
			2'b11: series_cells = 3'h4;
			2'b10: series_cells = 3'h3;
			2'b01: series_cells = 3'h2;
			default: series_cells = 3'h0;
		endcase
		rm_load_pulse = charge_term_valid & gauge_w[`GOCD_GA_SYNC]; // RULE_07
		independent_charger_learning = gauge_w[`GOCD_GA_INDEP]; // RULE_08
		end_threshold_compensation = gauge_w[`GOCD_GA_COMP]; // RULE_09
		end_voltage_basis = gauge_w[`GOCD_GA_EDV_PACK]; // RULE_10
		safety_voltage_basis = gauge_w[`GOCD_GA_OV_CELL]; // RULE_11
		continuous_midrange_fix = gauge_w[`GOCD_GA_CONT_FIX]; // RULE_12
		on_chip_sensor_select = misc_w[`GOCD_MI_SENSOR]; // RULE_13
		front_end_link_check = misc_w[`GOCD_MI_AFE_CHECK]; // RULE_14
		// The undefined code drives no switch at all rather than two.
		zero_volt_charge_switch = (pre_sel == GOCD_PRE_ZERO_VOLT); // RULE_20
		chg_precharge_switch = (pre_sel == GOCD_PRE_CHARGE); // RULE_20
		alt_precharge_switch = (pre_sel == GOCD_PRE_ALT); // RULE_20
	end

	// LED gating while charging and under a capacity alarm.
	logic led_shown;
	assign led_shown = discharging | misc_w[`GOCD_MI_CHG_DISP]; // RULE_17
	assign led_enable = led_shown &
		!(rca_alarm & misc_w[`GOCD_MI_ALARM_OFF]); // RULE_19
	assign led_blink = led_shown & rca_alarm &
		!misc_w[`GOCD_MI_ALARM_OFF]; // RULE_19

	////////////////////////////////////////////////////////////////////////
	// Bus pin synchronisers and the idle-sleep timer.
	logic [1:0] smb_meta_ff;
	logic [1:0] smb_sync_ff;
	logic [31:0] sleep_cnt_ff;
	logic [31:0] nxt_sleep_cnt;
	logic sleep_ff;
	logic nxt_sleep;
	logic bus_low;
	assign bus_low = !smb_sync_ff[0] & !smb_sync_ff[1];
	assign sleep_request = sleep_ff;

	// Any high level on either line restarts the two-second wait.
	always_comb begin
		nxt_sleep_cnt = 32'h0000_0000;
		nxt_sleep = 1'b0;
		if (bus_low && !misc_w[`GOCD_MI_SLEEP_INH]) begin // RULE_15
			nxt_sleep_cnt = sleep_cnt_ff;
			if (sleep_cnt_ff == 32'(SLEEP_CYCLES - 1)) begin
				nxt_sleep = 1'b1;
			end else begin
				nxt_sleep_cnt = sleep_cnt_ff + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			smb_meta_ff <= 2'b11;
			smb_sync_ff <= 2'b11;
			sleep_cnt_ff <= 32'h0000_0000;
			sleep_ff <= 1'b0;
		end else begin
			smb_meta_ff <= {smb_data_pin, smb_clk_pin};
			smb_sync_ff <= smb_meta_ff;
			sleep_cnt_ff <= nxt_sleep_cnt;
			sleep_ff <= nxt_sleep;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cell voltage flags, each with an optional one-second delay.
	logic [1:0] cell_raw;
	logic [1:0] cell_flag;
	assign cell_raw = {cell_low_raw, cell_high_raw};
	assign cell_high_flag = cell_flag[0];
	assign cell_low_flag = cell_flag[1];

	for (genvar g = 0; g < 2; g++) begin : g_cell
		logic [31:0] cnt_ff;
		logic [31:0] nxt_cnt;
		logic nxt_flag;
		logic flag_ff;
		// The flag drops as soon as the raw condition goes away.
		always_comb begin
			nxt_cnt = 32'h0000_0000;
			nxt_flag = 1'b0;
			if (cell_raw[g]) begin
				nxt_cnt = cnt_ff;
				if (!misc_w[`GOCD_MI_CELL_DLY] ||
					cnt_ff == 32'(DELAY_CYCLES - 1)) begin // RULE_18
					nxt_flag = 1'b1;
				end else begin
					nxt_cnt = cnt_ff + 32'h0000_0001;
				end
			end
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_ff <= 32'h0000_0000;
				flag_ff <= 1'b0;
			end else begin
				cnt_ff <= nxt_cnt;
				flag_ff <= nxt_flag;
			end
		end
	end
	// Each lane owns its own flop, so the vector has a single driver.
	assign cell_flag = {g_cell[1].flag_ff, g_cell[0].flag_ff};

	////////////////////////////////////////////////////////////////////////
	// Sticky state: front end failure, termination, one-shot, faults.
	logic afe_fail_ff, nxt_afe_fail;
	logic term_ff, nxt_term;
	logic oneshot_done_ff, nxt_oneshot_done;
	logic chg_fault_ff, nxt_chg_fault;
	logic dsg_fault_ff, nxt_dsg_fault;
	logic [31:0] sec_cnt_ff, nxt_sec_cnt;
	logic [7:0] clr_sec_ff, nxt_clr_sec;
	logic sec_tick, fixed_mode, clr_done, clr_chg, clr_dsg;

	assign fixed_mode = misc_w[`GOCD_MI_FIXED];
	assign sec_tick = (sec_cnt_ff == 32'(SECOND_CYCLES - 1));
	assign clr_done = (clr_sec_ff >= ctrl_w[`GOCD_CT_FRT_HI:`GOCD_CT_FRT_LO]);
	// Fixed batteries also clear on reverse current or a quiet average.
	assign clr_chg = pack_removed | (fixed_mode &
		(current_discharging | clr_done)); // RULE_21
	assign clr_dsg = pack_removed | (fixed_mode &
		(current_charging | clr_done)); // RULE_21

	// In every flag a new event beats a clear in the same cycle.
	always_comb begin
		nxt_afe_fail = afe_fail_ff;
		if (wr_en && slot == SLOT_STATUS && pstrb[0] &&
			pwdata[`GOCD_ST_AFE_FAIL]) begin
			nxt_afe_fail = 1'b0;
		end
		if (afe_comm_error && misc_w[`GOCD_MI_AFE_CHECK] &&
			ctrl_w[`GOCD_CT_PF_AFE]) begin // RULE_14
			nxt_afe_fail = 1'b1;
		end
		nxt_term = (term_ff & !charge_restart) | charge_term_valid;
		nxt_oneshot_done = oneshot_done_ff | midrange_oneshot_pulse;
		nxt_chg_fault = (chg_fault_ff & !clr_chg) | chg_fault_evt;
		nxt_dsg_fault = (dsg_fault_ff & !clr_dsg) | dsg_fault_evt;
		nxt_sec_cnt = sec_tick ? 32'h0000_0000 : sec_cnt_ff + 32'h0000_0001;
		nxt_clr_sec = 8'h00;
		if (fixed_mode && avg_below_clear &&
			(chg_fault_ff || dsg_fault_ff)) begin // RULE_21
			nxt_clr_sec = clr_sec_ff;
			if (sec_tick && !clr_done) begin
				nxt_clr_sec = clr_sec_ff + 8'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			afe_fail_ff <= 1'b0;
			term_ff <= 1'b0;
			oneshot_done_ff <= 1'b0;
			chg_fault_ff <= 1'b0;
			dsg_fault_ff <= 1'b0;
			sec_cnt_ff <= 32'h0000_0000;
			clr_sec_ff <= 8'h00;
		end else begin
			afe_fail_ff <= nxt_afe_fail;
			term_ff <= nxt_term;
			oneshot_done_ff <= nxt_oneshot_done;
			chg_fault_ff <= nxt_chg_fault;
			dsg_fault_ff <= nxt_dsg_fault;
			sec_cnt_ff <= nxt_sec_cnt;
			clr_sec_ff <= nxt_clr_sec;
		end
	end

	assign afe_fail_flag = afe_fail_ff;
	assign chg_fault = chg_fault_ff;
	assign dsg_fault = dsg_fault_ff;
	// Fires once, the first time the bit is seen after reset.
	assign midrange_oneshot_pulse = gauge_w[`GOCD_GA_ONE_FIX] &
		!oneshot_done_ff; // RULE_12

	// Switch drive; a removable pack drops both switches on any fault.
	assign chg_fet_on = !overtemp & !(term_ff & !misc_w[`GOCD_MI_RETAIN]) &
		!chg_fault_ff & !(dsg_fault_ff & !fixed_mode); // RULE_16 RULE_22
	assign dsg_fet_on = !(overtemp & misc_w[`GOCD_MI_OT_DSG]) &
		!dsg_fault_ff & !(chg_fault_ff & !fixed_mode); // RULE_16 RULE_21

	assign status_word = {9'h000, sleep_ff, cell_flag, dsg_fault_ff,
		chg_fault_ff, term_ff, afe_fail_ff};

	////////////////////////////////////////////////////////////////////////
	// Checks of the decoded behaviour.
	sequence s_pack_write;
		psel && penable && pwrite && slot == 4'h5 && pstrb[0];
	endsequence
	property p_led_src;
		@(posedge pclk) disable iff (!presetn)
		s_pack_write ##1 1'b1 |-> led_source_select == $past(pwdata[7]);
	endproperty
	a_led_src: assert property (p_led_src) else $error("LED source wrong"); // RULE_01
	property p_seg;
		@(posedge pclk) disable iff (!presetn)
		pack_w[6:5] == 2'b01 |-> led_segments == 3'h3;
	endproperty
	a_seg: assert property (p_seg) else $error("Segment count wrong"); // RULE_02
	property p_crc;
		@(posedge pclk) disable iff (!presetn)
		s_pack_write ##1 1'b1 |-> host_alert_crc_enable == $past(pwdata[4]);
	endproperty
	a_crc: assert property (p_crc) else $error("Host crc bit wrong"); // RULE_03
	property p_suppress;
		@(posedge pclk) disable iff (!presetn)
		pack_w[2] |-> !host_broadcast_enable && !charger_broadcast_enable;
	endproperty
	a_suppress: assert property (p_suppress) else $error("Broadcast leaked"); // RULE_05
	property p_cells;
		@(posedge pclk) disable iff (!presetn)
		pack_w[1:0] == 2'b10 |-> series_cells == 3'h3;
	endproperty
	a_cells: assert property (p_cells) else $error("Cell count wrong"); // RULE_06
	property p_rm;
		@(posedge pclk) disable iff (!presetn)
		rm_load_pulse |-> charge_term_valid && gauge_w[6];
	endproperty
	a_rm: assert property (p_rm) else $error("Capacity load wrong"); // RULE_07
	property p_oneshot;
		@(posedge pclk) disable iff (!presetn)
		midrange_oneshot_pulse |=> !midrange_oneshot_pulse [*8];
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("Fix repeated"); // RULE_12
	property p_sleep;
		@(posedge pclk) disable iff (!presetn)
		$rose(sleep_request) |-> $past(sleep_cnt_ff) ==
			32'(SLEEP_CYCLES - 1) && !misc_w[12];
	endproperty
	a_sleep: assert property (p_sleep) else $error("Early sleep"); // RULE_15
	property p_ot;
		@(posedge pclk) disable iff (!presetn)
		overtemp |-> !chg_fet_on && (dsg_fet_on || misc_w[11] ||
			dsg_fault_ff || chg_fault_ff);
	endproperty
	a_ot: assert property (p_ot) else $error("Overheat switch wrong"); // RULE_16
	property p_cell_now;
		@(posedge pclk) disable iff (!presetn)
		cell_high_raw && !misc_w[8] |=> cell_high_flag;
	endproperty
	a_cell_now: assert property (p_cell_now) else $error("Flag late"); // RULE_18
	property p_retain;
		@(posedge pclk) disable iff (!presetn)
		term_ff && misc_w[3] && !overtemp && !chg_fault_ff &&
			!dsg_fault_ff |-> chg_fet_on;
	endproperty
	a_retain: assert property (p_retain) else $error("Switch dropped"); // RULE_22
	property p_keep;
		@(posedge pclk) disable iff (!presetn)
		fixed_mode && chg_fault_ff && !dsg_fault_ff && !overtemp |->
			dsg_fet_on;
	endproperty
	a_keep: assert property (p_keep) else $error("Other switch off"); // RULE_21

endmodule

// *** sim/gocd_smb_partner.sv ***
// Far-side model of the management bus: the clock and the data lines.
// Assumes open-drain lines with pull-ups; models idle and held-low only.
`timescale 1ns/1ps
module gocd_smb_partner (
	input wire logic hold_low,
	output logic smb_clk_pin,
	output logic smb_data_pin
);
	// A released line returns to its pull-up level at once, so a stale
	// low never lingers. A held bus pulls both lines low together, which
	// is the condition the idle-sleep detector watches for.
	assign smb_clk_pin = hold_low ? 1'b0 : 1'b1;
	assign smb_data_pin = hold_low ? 1'b0 : 1'b1;
endmodule

// *** sim/test_gauge_option_config_decoder.sv ***
// Self-checking bench of the option decoder, driven over its APB slave.
// Assumes short count parameters so that timed behaviour fits the run.
`timescale 1ns/1ps
`include "gocd_regs.svh"
module test_gauge_option_config_decoder import gocd_pkg::*;;
	localparam logic [9:0] a_pack = {`GOCD_IDX_PACK, 2'b00};
	localparam logic [9:0] a_gauge = {`GOCD_IDX_GAUGE, 2'b00};
	localparam logic [9:0] a_misc = {`GOCD_IDX_MISC, 2'b00};
	localparam logic [9:0] a_ctrl = {`GOCD_IDX_CTRL, 2'b00};
	localparam logic [9:0] a_stat = {`GOCD_IDX_STATUS, 2'b00};
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [9:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, e, hold_low = 0, scl, sda;
	logic mbe = 0, ctv = 0, ot = 0, rca = 0, dsg = 0, chi = 0, clo = 0;
	logic cfe = 0, dfe = 0, crst = 0, acerr = 0, prm = 0, cchg = 0;
	logic abc = 0, os_seen = 0;
	logic led_src, host_crc, chg_crc, hbe, cbe, rm_load, indep, comp;
	logic edvb, ovb, cont, osp, sens, afec, afef, sleep, led_en, blink;
	logic chf, clf, zv, chs, alts, chg_on, dsg_on, chg_flt, dsg_flt;
	logic [2:0] segs, cells;
	logic [15:0] v;
	int bad_count = 0, check_count = 0;

	////////////////////////////////////////////////////////////////////
	// Clock at 50 MHz and the design under test with short counts.
	initial begin
		forever #10 pclk = ~pclk;
	end
	gocd_smb_partner gocd_smb_partner_i (.hold_low(hold_low),
		.smb_clk_pin(scl), .smb_data_pin(sda));
	gocd_top #(.SLEEP_CYCLES(20), .DELAY_CYCLES(10), .SECOND_CYCLES(5))
	gocd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .smb_clk_pin(scl),
		.smb_data_pin(sda), .mode_broadcast_enable(mbe),
		.charge_term_valid(ctv), .charge_restart(crst), .overtemp(ot),
		.rca_alarm(rca), .discharging(dsg), .cell_high_raw(chi),
		.cell_low_raw(clo), .afe_comm_error(acerr), .chg_fault_evt(cfe),
		.dsg_fault_evt(dfe), .pack_removed(prm),
		.current_charging(cchg), .current_discharging(1'b0),
		.avg_below_clear(abc), .led_source_select(led_src),
		.led_segments(segs), .host_alert_crc_enable(host_crc),
		.charger_broadcast_crc_enable(chg_crc),
		.host_broadcast_enable(hbe), .charger_broadcast_enable(cbe),
		.series_cells(cells), .rm_load_pulse(rm_load),
		.independent_charger_learning(indep),
		.end_threshold_compensation(comp), .end_voltage_basis(edvb),
		.safety_voltage_basis(ovb), .continuous_midrange_fix(cont),
		.midrange_oneshot_pulse(osp), .on_chip_sensor_select(sens),
		.front_end_link_check(afec), .afe_fail_flag(afef),
		.sleep_request(sleep), .led_enable(led_en), .led_blink(blink),
		.cell_high_flag(chf), .cell_low_flag(clf),
		.zero_volt_charge_switch(zv), .chg_precharge_switch(chs),
		.alt_precharge_switch(alts), .chg_fet_on(chg_on),
		.dsg_fet_on(dsg_on), .chg_fault(chg_flt), .dsg_fault(dsg_flt));

	////////////////////////////////////////////////////////////////////
	// Bus cycles; the wait is open-ended so a slow answer is still taken.
	task automatic apb(input logic w, input logic [9:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		apb(1, a, {16'h0000, d});
		@(posedge pclk);
	endtask
	// Every comparison is counted; a miss is reported at once.
	task automatic chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	function automatic logic [2:0] seg_exp(input logic [1:0] c);
		return (c == 2'h1) ? 3'h3 : (c == 2'h2) ? 3'h4 : 3'h5;
	endfunction
	function automatic logic [2:0] cell_exp(input logic [1:0] c);
		return (c == 2'h0) ? 3'h0 : 3'(c) + 3'h1;
	endfunction
	function automatic logic [2:0] pre_exp(input logic [1:0] c);
		return (c == 2'h3) ? 3'h0 : 3'h4 >> c;
	endfunction
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// Main sequence: reset, option words at random with every code.
	initial begin
		void'($urandom(91515));
		repeat (5) @(posedge pclk);
		presetn <= 1;
		apb(0, a_misc, 0);
		chk(r[15:0] === 16'h0200, "misc reset");
		apb(0, a_ctrl, 0);
		chk(r[15:0] === 16'h001E, "ctrl reset");
		chk(segs === 3'h5, "segments at reset");
		for (int i = 0; i < 12; i++) begin
			v = 16'($urandom) & 16'h00FF;
			v[6:5] = 2'(i);
			v[1:0] = 2'(i + 1);
			mbe <= 1'($urandom);
			wr(a_pack, v);
			chk(led_src === v[7], "led source");
			chk(segs === seg_exp(v[6:5]), "segments");
			chk(host_crc === v[4], "host crc");
			chk(chg_crc === v[3], "charger crc");
			chk({hbe, cbe} === {2{mbe & !v[2]}}, "broadcast");
			chk(cells === cell_exp(v[1:0]), "cells");
		end
		$display("pack options done");
		for (int i = 0; i < 8; i++) begin
			v = 16'($urandom) & 16'h007F;
			v[0] = i[2];
			wr(a_gauge, v);
			chk(osp === (v[0] & !os_seen), "one shot");
			os_seen = os_seen | v[0];
			ctv <= 1;
			@(posedge pclk);
			chk(rm_load === v[6], "capacity load");
			chk(indep === v[5], "learning");
			chk(comp === v[4], "compensation");
			chk(edvb === v[3], "end basis");
			chk(ovb === v[2], "safety basis");
			chk(cont === v[1], "midrange");
			ctv <= 0;
		end
		$display("gauge options done");
		for (int i = 0; i < 8; i++) begin
			v = (16'($urandom) & 16'hBDF8) | 16'h1200;
			v[6:5] = 2'(i);
			ot <= i[0];
			dsg <= i[1];
			rca <= i[2];
			wr(a_misc, v);
			chk(sens === v[15], "sensor");
			chk(afec === v[13], "front end check");
			chk(!ot || {chg_on, dsg_on} === {1'b0, !v[11]}, "heat");
			chk(dsg || rca || led_en === v[10], "charge leds");
			chk(!dsg || !rca || blink === !v[7], "alarm leds");
			chk({zv, chs, alts} === pre_exp(v[6:5]), "precharge");
		end
		ot <= 0;
		$display("misc options done");
		// Delayed cell flag, then an undelayed one.
		wr(a_misc, 16'h1300);
		chi <= 1;
		repeat (3) @(posedge pclk);
		chk(chf === 1'b0, "cell flag early");
		repeat (12) @(posedge pclk);
		chk(chf === 1'b1, "cell flag late");
		wr(a_misc, 16'h1200);
		clo <= 1;
		repeat (2) @(posedge pclk);
		chk(clf === 1'b1, "cell flag direct");
		$display("cell flags done");
		// Bus held low: sleep only while not inhibited.
		hold_low <= 1;
		repeat (30) @(posedge pclk);
		chk(sleep === 1'b0, "sleep inhibited");
		wr(a_misc, 16'h0200);
		repeat (30) @(posedge pclk);
		chk(sleep === 1'b1, "sleep entered");
		hold_low <= 0;
		$display("sleep done");
		// A removable pack drops both switches on a charge fault.
		cfe <= 1;
		@(posedge pclk);
		cfe <= 0;
		@(posedge pclk);
		chk({chg_flt, chg_on, dsg_on} === 3'b100, "fault");
		apb(0, 10'h3FC, 0);
		chk(e === 1'b1, "unmapped");
		// Removal clears the fault; restart ends the terminated state.
		{prm, crst} <= 2'b11;
		@(posedge pclk);
		{prm, crst, ctv} <= 3'b001;
		@(posedge pclk);
		ctv <= 0;
		chk({chg_flt, chg_on} === 2'b01, "removal clears");
		@(posedge pclk);
		chk(chg_on === 1'b0, "off after end");
		wr(a_misc, 16'h0208);
		chk(chg_on === 1'b1, "retained");
		// Fixed battery keeps the other switch on.
		wr(a_ctrl, 16'h0802);
		wr(a_misc, 16'h0218);
		dfe <= 1;
		@(posedge pclk);
		{dfe, cchg} <= 2'b01;
		@(posedge pclk);
		chk({dsg_flt, chg_on, dsg_on} === 3'b110, "keep");
		@(posedge pclk);
		chk(dsg_flt === 1'b0, "reverse clears");
		// A quiet average clears after two programmed seconds.
		{cchg, cfe, abc} <= 3'b011;
		@(posedge pclk);
		cfe <= 0;
		repeat (3) @(posedge pclk);
		chk(chg_flt === 1'b1, "fault held");
		repeat (15) @(posedge pclk);
		chk(chg_flt === 1'b0, "quiet clears");
		abc <= 0;
		$display("faults done");
		// Front end failure needs both enables; an error beats a clear.
		acerr <= 1;
		@(posedge pclk);
		acerr <= 0;
		@(posedge pclk);
		chk(afef === 1'b0, "check disabled");
		wr(a_misc, 16'h2218);
		acerr <= 1;
		wr(a_stat, 16'h0001);
		chk(afef === 1'b1, "set beats clear");
		acerr <= 0;
		wr(a_stat, 16'h0001);
		apb(0, a_stat, 0);
		chk(r[0] === 1'b0, "front end cleared");
		$display("front end done");
		complete_run;
	end

	// Watchdog far beyond the few hundred cycles the tests need.
	initial begin
		#400000;
		bad_count++;
		complete_run;
	end
endmodule
